// ===== core/drive_fault_pkg.sv
// Constants and types shared by the drive fault monitor
package drive_fault_pkg;
  // ------------------------------------------------------------
  // Time base
  // ------------------------------------------------------------
  localparam int CLK_KHZ = 125000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYCLES = TICK_MS * CLK_KHZ;
  localparam int MINUTE_MS = 60000;
  localparam int MINUTE_TICKS = MINUTE_MS / TICK_MS;
  localparam int DS_W = 10;
  // Times below count tenths of a second, one per tick
  localparam logic [DS_W-1:0] RESTART_CLEAR_DS = 10'h12C;
  localparam logic [DS_W-1:0] WARN_TIME_MAX_DS = 10'h12C;
  localparam logic [DS_W-1:0] TRIP_TIME_MAX_DS = 10'h258;
  // ------------------------------------------------------------
  // Levels in percent of motor rated current, and selects
  // ------------------------------------------------------------
  localparam int PCT_W = 8;
  localparam logic [PCT_W-1:0] LEVEL_MAX_PCT = 8'hC8;
  localparam logic [PCT_W-1:0] LEVEL_MIN_PCT = 8'h1E;
  localparam logic [PCT_W-1:0] WARN_MAX_PCT = 8'h96;
  localparam logic [PCT_W-1:0] CONT_MIN_PCT = 8'h32;
  localparam logic [PCT_W-1:0] CONT_LIMIT_PCT = 8'h96;
  localparam int FSEL_W = 5;
  localparam logic [FSEL_W-1:0] FSEL_MAX = 5'h13;
  localparam logic [FSEL_W-1:0] FSEL_WARN = 5'h05;
  localparam logic [FSEL_W-1:0] FSEL_STALL = 5'h07;
  localparam int STALL_ACCEL = 0;
  localparam int STALL_CONST = 1;
  localparam int STALL_DECEL = 2;
  // ------------------------------------------------------------
  // Records
  // ------------------------------------------------------------
  localparam int HISTORY_DEPTH = 5;
  localparam int FREQ_W = 16;
  localparam int RAMP_W = 16;
  localparam int FAULT_W = 8;
  localparam int EXT_TRIP_W = 6;
  localparam int FAULT_THERMAL = 0;
  localparam int FAULT_OVERLOAD = 1;

  typedef enum logic [1:0] {
    PHASE_IDLE = 2'h0,
    PHASE_CONST = 2'h1,
    PHASE_ACCEL = 2'h3,
    PHASE_DECEL = 2'h2
  } phase_type;

  typedef enum logic {
    REC_IDLE = 1'h0,
    REC_TRIPPED = 1'h1
  } rec_state_type;

  typedef struct packed {
    logic valid;
    logic [FAULT_W-1:0] code;
    logic [FREQ_W-1:0] freq;
    logic [PCT_W-1:0] current;
    phase_type phase;
  } record_type;

  typedef struct packed {
    logic thermal_protect_enable;
    logic cooling_type_select;
    logic [PCT_W-1:0] one_minute_thermal_level;
    logic [PCT_W-1:0] continuous_thermal_level;
    logic [PCT_W-1:0] overload_warn_level;
    logic [DS_W-1:0] overload_warn_time;
    logic overload_trip_enable;
    logic [PCT_W-1:0] overload_trip_level;
    logic [DS_W-1:0] overload_trip_time;
    logic [2:0] stall_prevent_select;
    logic [PCT_W-1:0] stall_current_level;
    logic [FSEL_W-1:0] relay_function_select;
    logic [FSEL_W-1:0] output2_function_select;
    logic fault_history_clear;
  } settings_type;

  localparam settings_type SETTINGS_RESET = '{
    thermal_protect_enable: 1'h0,
    cooling_type_select: 1'h0,
    one_minute_thermal_level: 8'h96,
    continuous_thermal_level: 8'h64,
    overload_warn_level: 8'h96,
    overload_warn_time: 10'h064,
    overload_trip_enable: 1'h1,
    overload_trip_level: 8'hB4,
    overload_trip_time: 10'h258,
    stall_prevent_select: 3'h0,
    stall_current_level: 8'h96,
    relay_function_select: 5'h11,
    output2_function_select: 5'h11,
    fault_history_clear: 1'h0
  };
endpackage

// ===== core/sync2.sv
// Two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o <= '0;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end
endmodule
`default_nettype wire

// ===== core/level_timer.sv
// Flags a quantity held above its level for a set number of ticks
`timescale 1ns/1ps
`default_nettype none
module level_timer
  import drive_fault_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Time base and comparison
  input wire logic tick_i,
  input wire logic over_i,
  input wire logic [DS_W-1:0] limit_i,
  // Result
  output logic expired_o
);
  logic [DS_W-1:0] count;
  logic [DS_W-1:0] next_count;
  logic next_expired;

  // Any dip below the level restarts the wait from zero
  always_comb begin
    next_count = count;
    if (!over_i) begin
      next_count = '0;
    end else if (tick_i && count < limit_i) begin
      next_count = count + 1'b1;
    end
    next_expired = over_i && (next_count >= limit_i);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= '0;
      expired_o <= 1'b0;
    end else begin
      count <= next_count;
      expired_o <= next_expired;
    end
  end

  property p_drop_below;
    @(posedge ref_clk_i) disable iff (rst_i)
    !over_i |=> !expired_o;
  endproperty
  a_drop_below: assert property (p_drop_below)
    else $error("flag stayed up after level dropped");

  property p_full_wait;
    @(posedge ref_clk_i) disable iff (rst_i)
    $rose(expired_o) |-> count >= limit_i && $past(over_i);
  endproperty
  a_full_wait: assert property (p_full_wait)
    else $error("flag rose before the full wait");
endmodule
`default_nettype wire

// ===== core/drive_fault_monitor.sv
// Drive fault recorder with thermal, overload and stall protection
`timescale 1ns/1ps
`default_nettype none
module drive_fault_monitor
  import drive_fault_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES,
  parameter int HISTORY_DEPTH_P = HISTORY_DEPTH,
  parameter logic [FREQ_W-1:0] LOW_SPEED_FREQ = 16'h07D0
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // Fault reset pins
  input wire logic fault_reset_key_i,
  input wire logic fault_reset_term_i,
  // Power stage and ramp state
  input wire logic [PCT_W-1:0] motor_current_i,
  input wire logic [FREQ_W-1:0] output_freq_i,
  input wire logic dc_bus_at_limit_i,
  input wire logic running_i,
  input wire logic accel_i,
  input wire logic decel_i,
  input wire logic [EXT_TRIP_W-1:0] ext_trip_i,
  input wire logic auto_restart_enable_i,
  input wire logic [RAMP_W-1:0] accel_ramp_time_i,
  input wire logic [RAMP_W-1:0] decel_ramp_time_i,
  // Settings
  input wire settings_type settings_i,
  input wire logic settings_write_i,
  output var settings_type settings_o,
  output logic settings_refused_o,
  // Fault records
  output var record_type current_fault_o,
  output var record_type [HISTORY_DEPTH_P-1:0] fault_history_o,
  // Drive control and relay outputs
  output logic output_block_o,
  output logic thermal_overload_trip_o,
  output logic stall_decel_o,
  output logic decel_hold_o,
  output logic [RAMP_W-1:0] ramp_time_o,
  output logic relay_contact_set_o,
  output logic output2_o,
  output logic restart_count_clear_o
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic in_range(input logic [PCT_W-1:0] v,
                                    input logic [PCT_W-1:0] lo,
                                    input logic [PCT_W-1:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  function automatic logic fsel_out(input logic [FSEL_W-1:0] sel,
                                    input logic warn,
                                    input logic stall);
    logic r;
    r = 1'b0;
    if (sel == FSEL_WARN) begin
      r = warn;
    end else if (sel == FSEL_STALL) begin
      r = stall;
    end
    return r;
  endfunction

  // Thermal fields read as zero while thermal protection is off
  function automatic settings_type view_of(input settings_type s);
    settings_type v;
    v = s;
    if (!s.thermal_protect_enable) begin
      v.cooling_type_select = 1'b0;
      v.one_minute_thermal_level = '0;
      v.continuous_thermal_level = '0;
    end
    return v;
  endfunction

  // ------------------------------------------------------------
  // Tick of one tenth of a second
  // ------------------------------------------------------------
  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES_P - 1);
  logic [23:0] tick_count;
  logic [23:0] next_tick_count;
  logic tick;
  logic next_tick;

  always_comb begin
    next_tick = (tick_count == TICK_LAST);
    next_tick_count = next_tick ? 24'h000000 : tick_count + 24'h000001;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_count <= '0;
      tick <= 1'b0;
    end else begin
      tick_count <= next_tick_count;
      tick <= next_tick;
    end
  end

  // ------------------------------------------------------------
  // Settings
  // ------------------------------------------------------------
  localparam settings_type VIEW_RESET = view_of(SETTINGS_RESET);
  settings_type settings;
  settings_type next_settings;
  settings_type next_view;
  settings_type w;
  logic next_refused;
  logic next_clear;
  logic clear_pulse;
  logic t_ok;
  logic ok;

  // A write with any field out of range is refused as a whole; thermal fields are checked only when thermal protection is enabled
  always_comb begin
    w = settings_i;
    t_ok = in_range(w.one_minute_thermal_level,
                    w.continuous_thermal_level, LEVEL_MAX_PCT) &&
           w.continuous_thermal_level >= CONT_MIN_PCT &&
           w.continuous_thermal_level < CONT_LIMIT_PCT &&
           w.continuous_thermal_level < w.one_minute_thermal_level;
    ok = (!w.thermal_protect_enable || t_ok) &&
         in_range(w.overload_warn_level, LEVEL_MIN_PCT, WARN_MAX_PCT) &&
         w.overload_warn_time <= WARN_TIME_MAX_DS &&
         in_range(w.overload_trip_level, LEVEL_MIN_PCT, LEVEL_MAX_PCT) &&
         w.overload_trip_time <= TRIP_TIME_MAX_DS &&
         in_range(w.stall_current_level, LEVEL_MIN_PCT, LEVEL_MAX_PCT) &&
         w.relay_function_select <= FSEL_MAX &&
         w.output2_function_select <= FSEL_MAX;
    next_settings = settings;
    next_refused = 1'b0;
    next_clear = 1'b0;
    if (settings_write_i) begin
      if (ok) begin
        next_settings = w;
        next_clear = w.fault_history_clear;
        next_settings.fault_history_clear = 1'b0;
        if (!w.thermal_protect_enable) begin
          next_settings.cooling_type_select = settings.cooling_type_select;
          next_settings.one_minute_thermal_level =
            settings.one_minute_thermal_level;
          next_settings.continuous_thermal_level =
            settings.continuous_thermal_level;
        end
      end else begin
        next_refused = 1'b1;
      end
    end
    next_view = view_of(next_settings);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      settings <= SETTINGS_RESET;
      settings_o <= VIEW_RESET;
      settings_refused_o <= 1'b0;
      clear_pulse <= 1'b0;
    end else begin
      settings <= next_settings;
      settings_o <= next_view;
      settings_refused_o <= next_refused;
      clear_pulse <= next_clear;
    end
  end

  // ------------------------------------------------------------
  // Protections
  // ------------------------------------------------------------
  logic warn_hit;
  logic trip_hit;
  logic [23:0] heat;
  logic [23:0] next_heat;
  logic [23:0] heat_limit;
  logic [8:0] excess;
  logic next_thermal;
  logic stall_over;
  logic stalled;
  logic next_stall_decel;
  logic next_decel_hold;
  logic [RAMP_W-1:0] next_ramp_time;
  logic next_relay;
  logic next_out2;
  logic ovl_event;
  phase_type phase_now;
  logic [FAULT_W-1:0] trip_code;

  level_timer u_warn (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .over_i(motor_current_i > settings.overload_warn_level),
    .limit_i(settings.overload_warn_time),
    .expired_o(warn_hit)
  );

  level_timer u_trip (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .over_i(motor_current_i > settings.overload_trip_level),
    .limit_i(settings.overload_trip_time),
    .expired_o(trip_hit)
  );

  always_comb begin
    phase_now = accel_i ? PHASE_ACCEL :
                decel_i ? PHASE_DECEL :
                running_i ? PHASE_CONST : PHASE_IDLE;
    stall_over = motor_current_i > settings.stall_current_level;
    stalled = stall_over || (decel_i && dc_bus_at_limit_i);
    // Heat grows with current above the continuous level; the trip
    // point is one minute of heating at the one-minute level
    excess = {1'b0, motor_current_i} -
             {1'b0, settings.continuous_thermal_level};
    if (!settings.cooling_type_select &&
        output_freq_i < LOW_SPEED_FREQ) begin
      excess = excess + {1'b0, excess[8:1]};
    end
    heat_limit = 24'(settings.one_minute_thermal_level -
                     settings.continuous_thermal_level) *
                 24'(MINUTE_TICKS);
    next_heat = heat;
    if (!settings.thermal_protect_enable) begin
      next_heat = '0;
    end else if (tick) begin
      if (motor_current_i > settings.continuous_thermal_level) begin
        if (heat < heat_limit) begin
          next_heat = heat + 24'(excess);
        end
      end else if (heat != 24'h000000) begin
        next_heat = heat - 24'h000001;
      end
    end
    next_thermal = settings.thermal_protect_enable &&
                   heat >= heat_limit;
    ovl_event = settings.overload_trip_enable && trip_hit;
    trip_code = {ext_trip_i, ovl_event, thermal_overload_trip_o};
    next_stall_decel = stall_over &&
      ((accel_i && settings.stall_prevent_select[STALL_ACCEL]) ||
       (phase_now == PHASE_CONST &&
        settings.stall_prevent_select[STALL_CONST]));
    next_decel_hold = decel_i && dc_bus_at_limit_i &&
      settings.stall_prevent_select[STALL_DECEL];
    // The external ramp uses the configured times while stall acts
    next_ramp_time = (next_stall_decel || decel_i) ?
                     decel_ramp_time_i : accel_ramp_time_i;
    next_relay = fsel_out(settings.relay_function_select,
                          warn_hit, stalled);
    next_out2 = fsel_out(settings.output2_function_select,
                         warn_hit, stalled);
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      heat <= '0;
      thermal_overload_trip_o <= 1'b0;
      stall_decel_o <= 1'b0;
      decel_hold_o <= 1'b0;
      ramp_time_o <= '0;
      relay_contact_set_o <= 1'b0;
      output2_o <= 1'b0;
    end else begin
      heat <= next_heat;
      thermal_overload_trip_o <= next_thermal;
      stall_decel_o <= next_stall_decel;
      decel_hold_o <= next_decel_hold;
      ramp_time_o <= next_ramp_time;
      relay_contact_set_o <= next_relay;
      output2_o <= next_out2;
    end
  end

  // ------------------------------------------------------------
  // Fault recorder and history
  // ------------------------------------------------------------
  logic [1:0] reset_sync;
  logic [1:0] reset_prev;
  logic reset_edge;
  rec_state_type state;
  rec_state_type next_state;
  record_type next_current;
  record_type [HISTORY_DEPTH_P-1:0] base;
  record_type [HISTORY_DEPTH_P-1:0] next_history;
  logic next_block;
  logic next_restart_clear;

  sync2 #(
    .WIDTH(2)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i({fault_reset_term_i, fault_reset_key_i}),
    .q_o(reset_sync)
  );

  // A clear and a reset in one cycle: history is erased first, then
  // the current record still lands in slot one
  always_comb begin
    reset_edge = |(reset_sync & ~reset_prev);
    next_state = state;
    next_current = current_fault_o;
    next_block = output_block_o;
    next_restart_clear = 1'b0;
    base = clear_pulse ? '0 : fault_history_o;
    next_history = base;
    unique case (state)
      REC_IDLE: begin
        if (running_i && |trip_code) begin
          next_state = REC_TRIPPED;
          next_current.valid = 1'b1;
          next_current.code = trip_code;
          next_current.freq = output_freq_i;
          next_current.current = motor_current_i;
          next_current.phase = phase_now;
          next_block = 1'b1;
          next_restart_clear = auto_restart_enable_i &&
            trip_code[FAULT_OVERLOAD] &&
            settings.overload_trip_time > RESTART_CLEAR_DS;
        end
      end
      REC_TRIPPED: begin
        if (reset_edge) begin
          next_history = {base[HISTORY_DEPTH_P-2:0],
                          current_fault_o};
          next_current = '0;
          next_state = REC_IDLE;
          next_block = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      reset_prev <= '0;
      state <= REC_IDLE;
      current_fault_o <= '0;
      fault_history_o <= '0;
      output_block_o <= 1'b0;
      restart_count_clear_o <= 1'b0;
    end else begin
      reset_prev <= reset_sync;
      state <= next_state;
      current_fault_o <= next_current;
      fault_history_o <= next_history;
      output_block_o <= next_block;
      restart_count_clear_o <= next_restart_clear;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_capture;
    @(posedge ref_clk_i) disable iff (rst_i)
    state == REC_IDLE && running_i && |trip_code |=>
      current_fault_o.valid && output_block_o &&
      current_fault_o.code == $past(trip_code) &&
      current_fault_o.current == $past(motor_current_i);
  endproperty
  a_capture: assert property (p_capture)
    else $error("trip not captured");

  property p_phase;
    @(posedge ref_clk_i) disable iff (rst_i)
    state == REC_IDLE && running_i && accel_i && |trip_code |=>
      current_fault_o.phase == PHASE_ACCEL;
  endproperty
  a_phase: assert property (p_phase)
    else $error("phase not recorded");

  property p_shift;
    @(posedge ref_clk_i) disable iff (rst_i)
    state == REC_TRIPPED && reset_edge && !clear_pulse |=>
      fault_history_o[0] == $past(current_fault_o) &&
      fault_history_o[HISTORY_DEPTH_P-1] ==
        $past(fault_history_o[HISTORY_DEPTH_P-2]) &&
      !current_fault_o.valid;
  endproperty
  a_shift: assert property (p_shift)
    else $error("history did not shift");

  property p_erase;
    @(posedge ref_clk_i) disable iff (rst_i)
    clear_pulse && !(state == REC_TRIPPED && reset_edge) |=>
      fault_history_o == '0;
  endproperty
  a_erase: assert property (p_erase)
    else $error("history not erased");

  property p_refuse_cont;
    @(posedge ref_clk_i) disable iff (rst_i)
    settings_write_i && settings_i.thermal_protect_enable &&
    settings_i.continuous_thermal_level >= CONT_LIMIT_PCT |=>
      settings_refused_o && settings == $past(settings);
  endproperty
  a_refuse_cont: assert property (p_refuse_cont)
    else $error("bad continuous level accepted");

  property p_accel_stall;
    @(posedge ref_clk_i) disable iff (rst_i)
    accel_i && settings.stall_prevent_select[STALL_ACCEL] &&
    motor_current_i > settings.stall_current_level |=> stall_decel_o;
  endproperty
  a_accel_stall: assert property (p_accel_stall)
    else $error("no stall deceleration");

  property p_decel_hold;
    @(posedge ref_clk_i) disable iff (rst_i)
    !(decel_i && dc_bus_at_limit_i) |=> !decel_hold_o;
  endproperty
  a_decel_hold: assert property (p_decel_hold)
    else $error("deceleration held without bus limit");

  property p_stall_relay;
    @(posedge ref_clk_i) disable iff (rst_i)
    settings.relay_function_select == FSEL_STALL && stalled |=>
      relay_contact_set_o;
  endproperty
  a_stall_relay: assert property (p_stall_relay)
    else $error("stall not shown on relay");

  property p_ovl_block;
    @(posedge ref_clk_i) disable iff (rst_i)
    $rose(ovl_event) && running_i && state == REC_IDLE |=>
      output_block_o ##1 output_block_o;
  endproperty
  a_ovl_block: assert property (p_ovl_block)
    else $error("overload did not block output");
endmodule
`default_nettype wire

// ===== verif/power_stage_model.sv
// Behavioural motor power stage feeding the fault monitor
`timescale 1ns/1ps
`default_nettype none
module power_stage_model
  import drive_fault_pkg::*;
(
  // Bench commands
  input wire logic [PCT_W-1:0] load_i,
  input wire logic [1:0] ramp_i,
  input wire logic block_i,
  // Measurements
  output logic [PCT_W-1:0] current_o,
  output logic [FREQ_W-1:0] freq_o,
  output logic running_o,
  output logic accel_o,
  output logic decel_o
);
  // A blocked output coasts the motor, so no current flows
  assign running_o = !block_i;
  assign current_o = block_i ? 8'h00 : load_i;
  assign freq_o = 16'h0BB8;
  assign accel_o = ramp_i[0];
  assign decel_o = ramp_i[1];
endmodule
`default_nettype wire

// ===== verif/tb_drive_fault_monitor.sv
// Self-checking bench for the drive fault monitor
`timescale 1ns/1ps
`default_nettype none
module tb_drive_fault_monitor
  import drive_fault_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic key = 1'b0;
  logic term = 1'b0;
  logic bus = 1'b0;
  logic hold, therm, rcc;
  logic [RAMP_W-1:0] rt;
  logic wr = 1'b0;
  logic blk, run, acc, dec, refused, relay, out2, sdec;
  logic [5:0] ext = 6'h00;
  logic [1:0] ramp = 2'h0;
  logic [PCT_W-1:0] load = 8'h00;
  logic [PCT_W-1:0] cur;
  logic [FREQ_W-1:0] freq;
  settings_type st = SETTINGS_RESET;
  settings_type s, so;
  record_type cf;
  record_type [HISTORY_DEPTH-1:0] hist;
  int n_mismatch = 0;
  int n_tests = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  power_stage_model ps (.load_i(load), .ramp_i(ramp), .block_i(blk),
    .current_o(cur), .freq_o(freq), .running_o(run), .accel_o(acc),
    .decel_o(dec));
  // Short tick keeps the timers within a brief run
  drive_fault_monitor #(.TICK_CYCLES_P(10)) dut (.ref_clk_i(ref_clk_i),
    .rst_i(rst_i), .fault_reset_key_i(key), .fault_reset_term_i(term),
    .motor_current_i(cur), .output_freq_i(freq), .dc_bus_at_limit_i(bus),
    .running_i(run), .accel_i(acc), .decel_i(dec), .ext_trip_i(ext),
    .auto_restart_enable_i(1'b1), .accel_ramp_time_i(16'h0064),
    .decel_ramp_time_i(16'h00C8), .settings_i(st), .settings_write_i(wr),
    .settings_o(so), .settings_refused_o(refused), .current_fault_o(cf),
    .fault_history_o(hist), .output_block_o(blk),
    .thermal_overload_trip_o(therm), .stall_decel_o(sdec),
    .decel_hold_o(hold), .ramp_time_o(rt), .relay_contact_set_o(relay),
    .output2_o(out2), .restart_count_clear_o(rcc));
  // ------------------------------------------------------------
  // Access and compare tasks
  // ------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk_bit(input string n, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %b seen %b", n, e, g);
    end
  endtask
  task automatic chk_byte(input string n, input logic [7:0] e,
                          input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wset(input settings_type v, input logic rf);
    @(negedge ref_clk_i);
    st = v;
    wr = 1'b1;
    @(negedge ref_clk_i);
    wr = 1'b0;
    chk_bit("refused", rf, refused);
  endtask
  task automatic trip(input logic [5:0] b);
    @(negedge ref_clk_i);
    ext = b;
    @(negedge ref_clk_i);
    ext = 6'h00;
  endtask
  // Key goes through a two-flop synchroniser, so hold it several cycles
  task automatic fclear(input logic use_term);
    @(negedge ref_clk_i);
    key = !use_term;
    term = use_term;
    repeat (4) @(negedge ref_clk_i);
    key = 1'b0;
    term = 1'b0;
    repeat (3) @(negedge ref_clk_i);
  endtask
  initial begin
    repeat (8000) @(posedge ref_clk_i);
    n_mismatch++;
    test_done();
  end
  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(negedge ref_clk_i);
    rst_i = 1'b0;
    chk_byte("relay sel", 8'h11, {3'h0, so.relay_function_select});
    chk_byte("cont lvl", 8'h00, so.continuous_thermal_level);
    s = SETTINGS_RESET;
    s.relay_function_select = 5'h14;
    wset(s, 1'b1);
    s = SETTINGS_RESET;
    s.thermal_protect_enable = 1'b1;
    s.continuous_thermal_level = 8'h96;
    s.one_minute_thermal_level = 8'hC8;
    wset(s, 1'b1);
    s.continuous_thermal_level = 8'h64;
    s.one_minute_thermal_level = 8'h63;
    wset(s, 1'b1);
    s.one_minute_thermal_level = 8'h96;
    wset(s, 1'b0);
    chk_byte("cont lvl", 8'h64, so.continuous_thermal_level);
    load = 8'h50;
    for (int i = 1; i <= 6; i++) begin
      ramp = (i % 2 == 1) ? 2'h1 : 2'h2;
      trip(6'(i));
      chk_byte("code", 8'(i << 2), cf.code);
      chk_byte("current", 8'h50, cf.current);
      chk_byte("phase", {6'h00, ramp == 2'h1 ? PHASE_ACCEL : PHASE_DECEL},
               {6'h00, cf.phase});
      fclear(1'b0);
    end
    chk_byte("slot one", 8'h18, hist[0].code);
    chk_byte("slot five", 8'h08, hist[4].code);
    ramp = 2'h0;
    trip(6'h03);
    chk_byte("code", 8'h0C, cf.code);
    chk_byte("phase", {6'h00, PHASE_CONST}, {6'h00, cf.phase});
    chk_bit("block", 1'b1, blk);
    fclear(1'b0);
    s = SETTINGS_RESET;
    s.fault_history_clear = 1'b1;
    wset(s, 1'b0);
    @(negedge ref_clk_i);
    chk_bit("hist valid", 1'b0, hist[0].valid);
    s = SETTINGS_RESET;
    s.relay_function_select = FSEL_STALL;
    s.output2_function_select = FSEL_WARN;
    s.overload_warn_level = 8'h32;
    s.overload_warn_time = 10'h002;
    s.stall_prevent_select = 3'h1;
    wset(s, 1'b0);
    ramp = 2'h1;
    load = 8'hC8;
    repeat (4) @(negedge ref_clk_i);
    chk_bit("stall relay", 1'b1, relay);
    chk_bit("stall decel", 1'b1, sdec);
    chk_bit("warn early", 1'b0, out2);
    repeat (30) @(negedge ref_clk_i);
    chk_bit("warn", 1'b1, out2);
    load = 8'h28;
    repeat (3) @(negedge ref_clk_i);
    chk_bit("warn drop", 1'b0, out2);
    chk_bit("stall relay", 1'b0, relay);
    s.overload_trip_level = 8'h64;
    s.overload_trip_time = 10'h003;
    wset(s, 1'b0);
    load = 8'hC8;
    repeat (50) @(negedge ref_clk_i);
    chk_byte("code", 8'h02, cf.code);
    chk_bit("block", 1'b1, blk);
    load = 8'h00;
    fclear(1'b1);
    chk_byte("slot one", 8'h02, hist[0].code);
    chk_bit("block", 1'b0, blk);
    s.overload_trip_time = 10'h12D;
    wset(s, 1'b0);
    load = 8'hC8;
    while (!blk) @(negedge ref_clk_i);
    chk_bit("restart clr", 1'b1, rcc);
    load = 8'h00;
    fclear(1'b0);
    s.thermal_protect_enable = 1'b1;
    s.one_minute_thermal_level = 8'h65;
    wset(s, 1'b0);
    load = 8'hC8;
    while (!blk) @(negedge ref_clk_i);
    chk_byte("code", 8'h01, cf.code);
    chk_bit("thermal", 1'b1, therm);
    load = 8'h00;
    // Let the heat fall below the limit so release does not retrip
    repeat (12) @(negedge ref_clk_i);
    fclear(1'b0);
    s.stall_prevent_select = 3'h4;
    wset(s, 1'b0);
    ramp = 2'h2;
    bus = 1'b1;
    repeat (2) @(negedge ref_clk_i);
    chk_bit("hold", 1'b1, hold);
    chk_bit("stall relay", 1'b1, relay);
    chk_byte("ramp", 8'hC8, rt[7:0]);
    bus = 1'b0;
    ramp = 2'h1;
    repeat (2) @(negedge ref_clk_i);
    chk_bit("hold", 1'b0, hold);
    chk_byte("ramp", 8'h64, rt[7:0]);
    test_done();
  end
endmodule
`default_nettype wire
